/* tlr_latch_top.sv */
// Control word decode and read-back for a three-counter interval timer
`timescale 1ns/1ps
`default_nettype none
`include "tlr_regs.svh"
module tlr_latch_top (
  input wire logic mclk_in, // System clock, 100 MHz
  input wire logic sys_rst_in, // Sync reset, active high
  input wire logic io_wr_in, // I/O write strobe, one cycle
  input wire logic io_rd_in, // I/O read strobe, one cycle
  input wire logic [7:0] io_addr_in, // I/O port address
  input wire logic [7:0] io_wdata_in, // I/O write data
  input wire logic [47:0] count_in, // Live counts, counter 0 lowest
  input wire logic [2:0] out_level_in, // Counter output levels
  input wire logic [2:0] null_count_in, // Count not yet in counting element
  output logic [7:0] io_rdata_out, // I/O read data
  output logic [2:0] prog_out // Counter programmed pulse
);
  logic ctrl_wr;
  logic [1:0] sel;
  logic [2:0] cnt_latch;
  logic [2:0] sts_latch;
  logic [2:0] rd_hit;
  logic [23:0] cmd_reg;
  logic [23:0] rd_bytes;
  logic [1:0] rd_idx_reg;

  function automatic logic [2:0] onehot(input logic [1:0] s);
    onehot = 3'h1 << s;
  endfunction

  // Control word decode
  assign ctrl_wr = io_wr_in && io_addr_in == `TLR_PORT_CTRL;
  assign sel = io_wdata_in[`TLR_CW_SEL_HI:`TLR_CW_SEL_LO];
  always_comb begin
    cnt_latch = 3'h0;
    sts_latch = 3'h0;
    prog_out = 3'h0;
    if (ctrl_wr) begin
      if (sel == `TLR_SEL_RDBK) begin
        if (!io_wdata_in[`TLR_CW_NOCNT]) begin
          cnt_latch = io_wdata_in[`TLR_CW_RB_C2:`TLR_CW_RB_C0];
        end
        if (!io_wdata_in[`TLR_CW_NOSTS]) begin
          sts_latch = io_wdata_in[`TLR_CW_RB_C2:`TLR_CW_RB_C0];
        end
      end else if (io_wdata_in[`TLR_CW_RW_HI:`TLR_CW_RW_LO] ==
                   `TLR_RW_LATCH) begin
        cnt_latch = onehot(sel);
      end else begin
        prog_out = onehot(sel);
      end
    end
  end

  // Per-counter programmed word: access mode, mode, count type
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      cmd_reg <= 24'h000000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (prog_out[i]) begin
          cmd_reg[i*8 +: 8] <= io_wdata_in;
        end
      end
    end
  end

  // Read hits per counter port
  assign rd_hit[0] = io_rd_in && io_addr_in == `TLR_PORT_CNT0;
  assign rd_hit[1] = io_rd_in && io_addr_in == `TLR_PORT_CNT1;
  assign rd_hit[2] = io_rd_in && io_addr_in == `TLR_PORT_CNT2;

  // One latch channel per counter
  for (genvar g = 0; g < 3; g++) begin : g_chan
    logic [7:0] sts;
    assign sts = {out_level_in[g], null_count_in[g],
                  cmd_reg[g*8 + 5 -: 6]};
    tlr_chan u_chan (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .cnt_latch_in(cnt_latch[g]),
      .sts_latch_in(sts_latch[g]),
      .rd_in(rd_hit[g]),
      .count_in(count_in[g*16 +: 16]),
      .status_in(sts),
      .rw_mode_in(cmd_reg[g*8 + 5 -: 2]),
      .prog_in(prog_out[g]),
      .rd_data_out(rd_bytes[g*8 +: 8])
    );
  end

  // Remember which counter was read to steer read data
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rd_idx_reg <= 2'h0;
    end else if (rd_hit[1]) begin
      rd_idx_reg <= 2'h1;
    end else if (rd_hit[2]) begin
      rd_idx_reg <= 2'h2;
    end else if (rd_hit[0]) begin
      rd_idx_reg <= 2'h0;
    end
  end

  // Read data mux from channel flip-flops
  always_comb begin
    unique case (rd_idx_reg)
      2'h1: io_rdata_out = rd_bytes[15:8];
      2'h2: io_rdata_out = rd_bytes[23:16];
      default: io_rdata_out = rd_bytes[7:0];
    endcase
  end

  // Command shapes seen on a control word write
  sequence rb_status_req;
    ctrl_wr && sel == `TLR_SEL_RDBK && !io_wdata_in[`TLR_CW_NOSTS];
  endsequence

  sequence rb_count_req;
    ctrl_wr && sel == `TLR_SEL_RDBK && !io_wdata_in[`TLR_CW_NOCNT];
  endsequence

  sequence latch_cmd;
    ctrl_wr && sel != `TLR_SEL_RDBK &&
      io_wdata_in[`TLR_CW_RW_HI:`TLR_CW_RW_LO] == `TLR_RW_LATCH;
  endsequence

  sequence prog_cmd;
    ctrl_wr && sel != `TLR_SEL_RDBK &&
      io_wdata_in[`TLR_CW_RW_HI:`TLR_CW_RW_LO] != `TLR_RW_LATCH;
  endsequence

  // Control word decode checks
  chk_rb_select: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    rb_status_req |-> sts_latch ==
      io_wdata_in[`TLR_CW_RB_C2:`TLR_CW_RB_C0])
    else $error("read-back select wrong");
  chk_rb_nocnt: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    ctrl_wr && sel == `TLR_SEL_RDBK && io_wdata_in[`TLR_CW_NOCNT]
      |-> cnt_latch == 3'h0)
    else $error("count latched with bit 5 set");
  chk_cl_select: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    latch_cmd |-> cnt_latch == onehot(sel) && sts_latch == 3'h0)
    else $error("latch command selects wrong counter");

  // Count latch follows the read-back select bits
  chk_rb_count: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    rb_count_req |-> cnt_latch ==
      io_wdata_in[`TLR_CW_RB_C2:`TLR_CW_RB_C0])
    else $error("read-back count select wrong");

  // Status stays unlatched when bit 4 is set
  chk_rb_nosts: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    ctrl_wr && sel == `TLR_SEL_RDBK && io_wdata_in[`TLR_CW_NOSTS]
      |-> sts_latch == 3'h0)
    else $error("status latched with bit 4 set");

  // A read-back command never reprograms a counter
  chk_rb_noprog: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    ctrl_wr && sel == `TLR_SEL_RDBK |-> prog_out == 3'h0)
    else $error("read-back command programmed a counter");

  // A latch command leaves the programmed word alone
  chk_latch_noprog: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    latch_cmd |-> prog_out == 3'h0)
    else $error("latch command programmed a counter");

  // Programming touches only the counter it names
  chk_prog_one: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    prog_cmd |-> prog_out == onehot(sel) && cnt_latch == 3'h0 &&
      sts_latch == 3'h0)
    else $error("programming word decoded wrong");

  // Nothing is latched or programmed without a control word write
  chk_idle_quiet: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    !ctrl_wr |-> cnt_latch == 3'h0 && sts_latch == 3'h0 &&
      prog_out == 3'h0)
    else $error("latch or program without a control write");

  // Read data is steered to the counter whose port was read
  chk_steer_one: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    io_rd_in && io_addr_in == `TLR_PORT_CNT1 |=> rd_idx_reg == 2'h1)
    else $error("counter 1 read steered wrong");
  chk_steer_two: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    io_rd_in && io_addr_in == `TLR_PORT_CNT2 |=> rd_idx_reg == 2'h2)
    else $error("counter 2 read steered wrong");

  // Read data stands until the next read of a counter port
  chk_rdata_hold: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    !io_rd_in |=> $stable(io_rdata_out))
    else $error("read data changed without a read");
endmodule // tlr_latch_top
`default_nettype wire

/* tlr_regs.svh */
// Port offsets, field positions and reset values of the timer latch block
`ifndef TLR_REGS_SVH
`define TLR_REGS_SVH
`define TLR_PORT_CNT0 8'h40
`define TLR_PORT_CNT1 8'h41
`define TLR_PORT_CNT2 8'h42
`define TLR_PORT_CTRL 8'h43
`define TLR_CW_SEL_HI 7
`define TLR_CW_SEL_LO 6
`define TLR_CW_RW_HI 5
`define TLR_CW_RW_LO 4
`define TLR_CW_NOCNT 5
`define TLR_CW_NOSTS 4
`define TLR_CW_RB_C2 3
`define TLR_CW_RB_C0 1
`define TLR_SEL_RDBK 2'h3
`define TLR_RW_LATCH 2'h0
`define TLR_RW_LSB 2'h1
`define TLR_RW_MSB 2'h2
`define TLR_RW_BOTH 2'h3
`define TLR_STS_OUT 7
`define TLR_STS_NULL 6
`define TLR_STS_RESET 8'h00
`endif

/* tlr_pkg.sv */
// Types shared by the timer latch block
`default_nettype none
package tlr_pkg;
  typedef enum logic [1:0] {
    TLR_RD_LSB,
    TLR_RD_MSB
  } tlr_byte_t;
endpackage
`default_nettype wire

/* tlr_chan.sv */
// One counter's latch and read-out sequencing
`timescale 1ns/1ps
`default_nettype none
`include "tlr_regs.svh"
module tlr_chan (
  input wire logic mclk_in, // System clock
  input wire logic sys_rst_in, // Sync reset, active high
  input wire logic cnt_latch_in, // Latch count request
  input wire logic sts_latch_in, // Latch status request
  input wire logic rd_in, // Read of this counter's port
  input wire logic [15:0] count_in, // Live counting element value
  input wire logic [7:0] status_in, // Live status byte
  input wire logic [1:0] rw_mode_in, // Programmed access mode
  input wire logic prog_in, // Control word reprogrammed this counter
  output logic [7:0] rd_data_out // Byte returned on a read
);
  logic [15:0] cnt_hold_reg;
  logic cnt_valid_reg;
  logic [7:0] sts_hold_reg;
  logic sts_valid_reg;
  tlr_pkg::tlr_byte_t byte_reg;
  logic [15:0] src;
  logic rd_cnt;

  // A read takes status first, otherwise a count byte
  assign rd_cnt = rd_in && !sts_valid_reg;
  assign src = cnt_valid_reg ? cnt_hold_reg : count_in;

  // Status latch; first latch wins until read
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sts_valid_reg <= 1'b0;
      sts_hold_reg <= `TLR_STS_RESET;
    end else if (sts_latch_in && !sts_valid_reg) begin
      sts_valid_reg <= 1'b1;
      sts_hold_reg <= status_in;
    end else if (rd_in && sts_valid_reg) begin
      sts_valid_reg <= 1'b0;
    end
  end

  // Count latch; held until every byte is read
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      cnt_valid_reg <= 1'b0;
      cnt_hold_reg <= 16'h0000;
    end else if (cnt_latch_in && !cnt_valid_reg) begin
      cnt_valid_reg <= 1'b1;
      cnt_hold_reg <= count_in;
    end else if (rd_cnt && cnt_valid_reg &&
                 (rw_mode_in != `TLR_RW_BOTH ||
                  byte_reg == tlr_pkg::TLR_RD_MSB)) begin
      cnt_valid_reg <= 1'b0;
    end
  end

  // Byte pointer for two-byte reads, private to this counter
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || prog_in) begin
      byte_reg <= tlr_pkg::TLR_RD_LSB;
    end else if (rd_cnt && rw_mode_in == `TLR_RW_BOTH) begin
      byte_reg <= (byte_reg == tlr_pkg::TLR_RD_LSB) ?
                  tlr_pkg::TLR_RD_MSB : tlr_pkg::TLR_RD_LSB;
    end
  end

  // Registered read data
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_in) begin
      if (sts_valid_reg) begin
        rd_data_out <= sts_hold_reg;
      end else if (rw_mode_in == `TLR_RW_MSB ||
                   (rw_mode_in == `TLR_RW_BOTH &&
                    byte_reg == tlr_pkg::TLR_RD_MSB)) begin
        rd_data_out <= src[15:8];
      end else begin
        rd_data_out <= src[7:0];
      end
    end
  end

  chk_sts_first: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    rd_in && sts_valid_reg |=> rd_data_out == $past(sts_hold_reg))
    else $error("status byte not returned first");
  chk_latch_hold: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    cnt_valid_reg && cnt_latch_in |=> $stable(cnt_hold_reg))
    else $error("second latch overwrote held count");
  chk_latch_take: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    cnt_latch_in && !cnt_valid_reg |=>
      cnt_valid_reg && cnt_hold_reg == $past(count_in))
    else $error("count not captured");
  chk_two_byte: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    rd_cnt && cnt_valid_reg && rw_mode_in == `TLR_RW_BOTH &&
      byte_reg == tlr_pkg::TLR_RD_LSB && !prog_in |=> cnt_valid_reg)
    else $error("latch released after one byte");
  chk_release: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    rd_cnt && cnt_valid_reg && rw_mode_in != `TLR_RW_BOTH &&
      !cnt_latch_in |=> !cnt_valid_reg)
    else $error("latch not released");
endmodule // tlr_chan
`default_nettype wire

/* tlr_host.sv */
// Host software model issuing I/O port cycles to the timer latch block
`timescale 1ns/1ps
`default_nettype none
module tlr_host (
  input wire logic mclk_in, // System clock
  input wire logic [7:0] rdata_in, // Read data from the block
  output logic wr_out, // Write strobe
  output logic rd_out, // Read strobe
  output logic [7:0] addr_out, // Port address
  output logic [7:0] wdata_out // Write data
);
  // Idle bus at time zero
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // One write; callers leave reserved command bits at zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge mclk_in);
    wr_out = 1'b0;
    addr_out = ~a; // Released bus keeps no stale value
    wdata_out = ~d;
  endtask
  // One read; a two-byte read is finished by the same caller, except counter 1 in t_sts_only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge mclk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask
endmodule // tlr_host
`default_nettype wire

/* timer_latch_readback_tb.sv */
// Self-checking testbench of the timer latch and read-back block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
  errors++; $display("unexpected %s exp %h got %h", n, e, a); end end
module timer_latch_readback_tb;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic io_wr_in, io_rd_in;
  logic [7:0] io_addr_in, io_wdata_in, io_rdata_out;
  logic [15:0] cnt [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic [2:0] out_level_in = 3'h0;
  logic [2:0] null_count_in = 3'h0;
  logic [2:0] prog_out;
  int errors = 0;
  int total_checks = 0;
  // Clock and live counts
  always #5 mclk_in = ~mclk_in;
  tlr_host host (.mclk_in(mclk_in), .rdata_in(io_rdata_out),
    .wr_out(io_wr_in), .rd_out(io_rd_in), .addr_out(io_addr_in),
    .wdata_out(io_wdata_in));
  tlr_latch_top DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_addr_in(io_addr_in),
    .io_wdata_in(io_wdata_in), .count_in({cnt[2], cnt[1], cnt[0]}),
    .out_level_in(out_level_in), .null_count_in(null_count_in),
    .io_rdata_out(io_rdata_out), .prog_out(prog_out));
  // Reads a port and compares the byte
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
      input string n);
    logic [7:0] d;
    host.rd(a, d);
    `CHK(n, e, d)
  endtask
  // Writes a control word and checks the programming pulse mid-write
  task automatic wrchk(input logic [7:0] d, input logic [2:0] e);
    fork
      host.wr(8'h43, d);
      begin
        @(negedge mclk_in);
        @(posedge mclk_in);
        `CHK("prog pulse", e, prog_out)
      end
    join
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reset value and status of an unprogrammed counter
  task automatic t_reset();
    `CHK("rdata at reset", 8'h00, io_rdata_out)
    host.wr(8'h43, 8'he8);
    rdchk(8'h42, 8'h00, "ctr2 reset status");
    $display("t_reset done");
  endtask
  // Latch command on each counter, count moves on after the latch
  task automatic t_latch();
    for (int n = 0; n < 3; n++) begin
      host.wr(8'h43, {n[1:0], 6'h30});
      cnt[n] = 16'h1234 + 16'(n);
      host.wr(8'h43, {n[1:0], 6'h00});
      cnt[n] = 16'hffff;
      rdchk(8'h40 + 8'(n), 8'h34 + 8'(n), "latched lsb");
      rdchk(8'h40 + 8'(n), 8'h12, "latched msb");
    end
    $display("t_latch done");
  endtask
  // Second latch ignored until the first is read, then live again
  task automatic t_double();
    cnt[0] = 16'h5678;
    host.wr(8'h43, 8'h00);
    cnt[0] = 16'ha1a1;
    host.wr(8'h43, 8'h00);
    rdchk(8'h40, 8'h78, "first latch lsb");
    rdchk(8'h40, 8'h56, "first latch msb");
    rdchk(8'h40, 8'ha1, "live lsb");
    rdchk(8'h40, 8'ha1, "live msb");
    $display("t_double done");
  endtask
  // Read-back of count and status: status first, then count bytes
  task automatic t_readback();
    out_level_in = 3'h1;
    cnt[0] = 16'h9abc;
    host.wr(8'h43, 8'hc2);
    cnt[0] = 16'h0f0f;
    out_level_in = 3'h0;
    rdchk(8'h40, 8'hb0, "rb status");
    rdchk(8'h40, 8'hbc, "rb lsb");
    rdchk(8'h40, 8'h9a, "rb msb");
    $display("t_readback done");
  endtask
  // Status-only read-back of counter 1; counter 0 not selected
  task automatic t_sts_only();
    host.wr(8'h43, 8'h70);
    null_count_in = 3'h2;
    cnt[0] = 16'h1111;
    cnt[1] = 16'h2222;
    host.wr(8'h43, 8'he4);
    null_count_in = 3'h0;
    cnt[0] = 16'h3344;
    cnt[1] = 16'h5566;
    rdchk(8'h40, 8'h44, "unselected ctr0");
    rdchk(8'h40, 8'h33, "unselected ctr0 msb");
    rdchk(8'h41, 8'h70, "ctr1 status");
    rdchk(8'h41, 8'h66, "ctr1 count unlatched");
    $display("t_sts_only done");
  endtask
  // Other counters accessed between the two bytes of counter 0
  task automatic t_interleave();
    cnt[0] = 16'hbeef;
    host.wr(8'h43, 8'h00);
    rdchk(8'h40, 8'hef, "ctr0 lsb");
    cnt[2] = 16'hcafe;
    host.wr(8'h43, 8'h80);
    rdchk(8'h42, 8'hfe, "ctr2 lsb");
    rdchk(8'h42, 8'hca, "ctr2 msb");
    host.wr(8'h43, 8'h70);
    cnt[0] = 16'h0000;
    rdchk(8'h40, 8'hbe, "ctr0 msb");
    $display("t_interleave done");
  endtask
  // Reset in mid-run drops a held latch and the programmed word
  task automatic t_reset_mid();
    cnt[0] = 16'h4321;
    wrchk(8'h00, 3'h0);
    @(negedge mclk_in);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    `CHK("rdata after reset", 8'h00, io_rdata_out)
    cnt[0] = 16'h8765;
    rdchk(8'h40, 8'h65, "live after reset");
    wrchk(8'he2, 3'h0);
    rdchk(8'h40, 8'h00, "status after reset");
    $display("t_reset_mid done");
  endtask
  // One-byte access modes release the latch after a single read
  task automatic t_single();
    wrchk(8'ha0, 3'h4);
    cnt[2] = 16'h7788;
    wrchk(8'h80, 3'h0);
    cnt[2] = 16'h1357;
    rdchk(8'h42, 8'h77, "msb mode latched");
    rdchk(8'h42, 8'h13, "msb mode live");
    wrchk(8'h90, 3'h4);
    wrchk(8'he8, 3'h0);
    rdchk(8'h42, 8'h10, "lsb mode status");
    cnt[2] = 16'h2468;
    wrchk(8'hd8, 3'h0);
    cnt[2] = 16'h0000;
    rdchk(8'h42, 8'h68, "lsb mode latched");
    rdchk(8'h42, 8'h00, "lsb mode live");
    $display("t_single done");
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_latch();
    t_double();
    t_readback();
    t_sts_only();
    t_interleave();
    t_reset_mid();
    t_single();
    end_sim();
  end
  // Watchdog well beyond the hundred or so cycles of the tests
  initial begin
    #100us;
    errors++;
    end_sim();
  end
endmodule // timer_latch_readback_tb
`default_nettype wire
